/* erc_pkg.sv */
// Constants for the E1 receive control register bank
package erc_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CHIP_IDENTITY = 6'h0f;
    localparam logic [ADDR_W-1:0] ADDR_RECEIVE_CONTROL = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_COMMON_CONTROL_FOUR = 6'h15;
    localparam logic [ADDR_W-1:0] ADDR_COMMON_CONTROL_FIVE = 6'h16;
    localparam logic [ADDR_W-1:0] ADDR_FACTORY_TEST = 6'h1e;
    // Device code in the identity register upper nibble; value is arbitrary
    localparam logic [3:0] DEVICE_CODE = 4'h5;
    // Chip revision in the lower nibble; value is arbitrary
    localparam logic [3:0] CHIP_REVISION = 4'h1;
    // Receive control field positions
    localparam int RC_MF_KIND = 7;
    localparam int RC_MODE = 6;
    localparam int RC_DIR = 5;
    localparam int RC_BUF_EN = 4;
    localparam int RC_CRITERIA = 2;
    localparam int RC_AUTO_DIS = 1;
    localparam int RC_RESYNC = 0;
    // Reset request bit positions in the common control registers
    localparam int CC5_LINE_RST = 4;
    localparam int CC4_ES_RST_LO = 5;
    localparam int CC4_ES_RST_HI = 6;
    // Register contents after reset (host must rewrite all anyway)
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    // Consecutive errors that call for a resync
    localparam logic [1:0] ERR_LIMIT = 2'h3;
    // Line interface recovery time and its cycle count at 250 MHz
    localparam int LINE_RECOVER_MS = 40;
    localparam int CLK_MHZ = 250;
    localparam int LINE_RECOVER_CYC = LINE_RECOVER_MS * 1000 * CLK_MHZ;
endpackage : erc_pkg

/* erc_receive_control_regs.sv */
// Receive control, identity and test register bank for one E1 transceiver
`timescale 1ns/1ps
module erc_receive_control_regs #(
    parameter int RECOVER_CYC = erc_pkg::LINE_RECOVER_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic transceiver_select_low,
    input wire logic transceiver_select_high,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [erc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [erc_pkg::DATA_W-1:0] reg_wdata,
    output logic [erc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic fas_check,
    input wire logic fas_err,
    input wire logic nfas_check,
    input wire logic nfas_bit2_err,
    input wire logic frame_boundary,
    input wire logic cas_mf_boundary,
    input wire logic crc4_mf_boundary,
    output logic receive_frame_pulse_out,
    output logic receive_frame_pulse_oe,
    output logic receive_buffer_enable,
    output logic resync_start,
    output logic line_interface_reset,
    output logic line_interface_busy,
    output logic [1:0] elastic_store_reset
);
    import erc_pkg::*;

    logic [DATA_W-1:0] rcv_ctl_reg;
    logic [DATA_W-1:0] test_reg;
    logic [DATA_W-1:0] cc4_reg;
    logic [DATA_W-1:0] cc5_reg;
    logic [1:0] sel_meta_reg;
    logic [1:0] sel_sync_reg;
    logic resync_req_reg;
    logic [1:0] fas_cnt_reg;
    logic [1:0] nfas_cnt_reg;
    logic [31:0] recover_cnt_reg;
    logic pulse_reg;
    logic [DATA_W-1:0] rdata_reg;

    // Address decode
    wire is_first = (sel_sync_reg == 2'b00);
    wire hit_id = (reg_addr == ADDR_CHIP_IDENTITY) && is_first;
    wire hit_rc = (reg_addr == ADDR_RECEIVE_CONTROL);
    wire hit_c4 = (reg_addr == ADDR_COMMON_CONTROL_FOUR);
    wire hit_c5 = (reg_addr == ADDR_COMMON_CONTROL_FIVE);
    wire hit_tst = (reg_addr == ADDR_FACTORY_TEST);
    wire wr_rc = reg_wr && hit_rc;
    wire wr_c4 = reg_wr && hit_c4;
    wire wr_c5 = reg_wr && hit_c5;
    wire wr_tst = reg_wr && hit_tst;
    wire [DATA_W-1:0] id_value = {DEVICE_CODE, CHIP_REVISION};

    // Read mux; identity is read-only, absent or unmapped reads give zero
    wire [DATA_W-1:0] rd_mux =
        hit_id ? id_value :
        hit_rc ? rcv_ctl_reg :
        hit_c4 ? cc4_reg :
        hit_c5 ? cc5_reg :
        hit_tst ? test_reg : REG_RESET;

    // Request bits in one vector: 0 line reset, 1 and 2 elastic store, 3 resync
    localparam int REQ_N = 4;
    wire [REQ_N-1:0] req_wr = {wr_rc, wr_c4, wr_c4, wr_c5};
    wire [REQ_N-1:0] req_new = {reg_wdata[RC_RESYNC], reg_wdata[CC4_ES_RST_HI],
        reg_wdata[CC4_ES_RST_LO], reg_wdata[CC5_LINE_RST]};
    wire [REQ_N-1:0] req_old = {rcv_ctl_reg[RC_RESYNC], cc4_reg[CC4_ES_RST_HI],
        cc4_reg[CC4_ES_RST_LO], cc5_reg[CC5_LINE_RST]};
    wire [REQ_N-1:0] req_edge;

    // Rising edges of stored bits on a write; rewriting a set bit asks for nothing
    genvar gi;
    generate
        for (gi = 0; gi < REQ_N; gi++) begin : g_edge
            assign req_edge[gi] = req_wr[gi] && req_new[gi] && !req_old[gi];
        end
    endgenerate

    // Named edges for the pulse logic below
    wire line_edge = req_edge[0];
    wire es_lo_edge = req_edge[1];
    wire es_hi_edge = req_edge[2];
    wire resync_edge = req_edge[3];

    // Resync criteria and automatic resync
    wire fas_hit = fas_check && fas_err && (fas_cnt_reg == ERR_LIMIT - 2'h1);
    wire nfas_hit = nfas_check && nfas_bit2_err && (nfas_cnt_reg == ERR_LIMIT - 2'h1);
    wire crit_met = fas_hit || (rcv_ctl_reg[RC_CRITERIA] && nfas_hit);
    wire auto_resync = crit_met && !rcv_ctl_reg[RC_AUTO_DIS];

    // Receive pulse source selection
    wire mf_src = rcv_ctl_reg[RC_MF_KIND] ? crc4_mf_boundary : cas_mf_boundary;
    wire pulse_src = rcv_ctl_reg[RC_MODE] ? mf_src : frame_boundary;

    // Pin input only when elastic store is on; otherwise the pin stays driven
    assign receive_frame_pulse_oe = !(rcv_ctl_reg[RC_DIR] && rcv_ctl_reg[RC_BUF_EN]);
    assign receive_buffer_enable = rcv_ctl_reg[RC_BUF_EN];
    assign receive_frame_pulse_out = pulse_reg;
    assign resync_start = resync_req_reg;
    assign line_interface_busy = (recover_cnt_reg != 32'h0);
    assign reg_rdata = rdata_reg;

    // Transceiver select straps pass two flip-flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_meta_reg <= 2'b00;
            sel_sync_reg <= 2'b00;
        end else begin
            sel_meta_reg <= {transceiver_select_high, transceiver_select_low};
            sel_sync_reg <= sel_meta_reg;
        end
    end

    // Register storage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rcv_ctl_reg <= REG_RESET;
            test_reg <= REG_RESET;
            cc4_reg <= REG_RESET;
            cc5_reg <= REG_RESET;
        end else begin
            if (wr_rc) rcv_ctl_reg <= reg_wdata;
            if (wr_tst) test_reg <= reg_wdata;
            if (wr_c4) cc4_reg <= reg_wdata;
            if (wr_c5) cc5_reg <= reg_wdata;
        end
    end

    // Read data register, loaded on a read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= REG_RESET;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    // Next counts of the error runs; a good word restarts the run
    wire counters_clear = crit_met || resync_edge;
    wire [1:0] fas_cnt_next = fas_err ? fas_cnt_reg + 2'h1 : 2'h0;
    wire [1:0] nfas_cnt_next = nfas_bit2_err ? nfas_cnt_reg + 2'h1 : 2'h0;

    // Next value of the recovery timer, reloaded by each line reset request
    wire recover_run = (recover_cnt_reg != 32'h0);
    wire [31:0] recover_cnt_next =
        line_edge ? 32'(RECOVER_CYC) :
        recover_run ? recover_cnt_reg - 32'h1 : recover_cnt_reg;

    // FAS error run; any resync starts the count again
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fas_cnt_reg <= 2'h0;
        end else if (counters_clear) begin
            fas_cnt_reg <= 2'h0;
        end else if (fas_check) begin
            fas_cnt_reg <= fas_cnt_next;
        end
    end

    // Non-FAS bit 2 error run; counted always, used only when the criterion asks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nfas_cnt_reg <= 2'h0;
        end else if (counters_clear) begin
            nfas_cnt_reg <= 2'h0;
        end else if (nfas_check) begin
            nfas_cnt_reg <= nfas_cnt_next;
        end
    end

    // Resync request pulse, from the host bit or from the criteria
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resync_req_reg <= 1'b0;
        end else begin
            resync_req_reg <= resync_edge || auto_resync;
        end
    end

    // Line interface reset pulse, one cycle per zero-to-one write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_interface_reset <= 1'b0;
        end else begin
            line_interface_reset <= line_edge;
        end
    end

    // Elastic store reset pulses, one per bit written from zero to one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            elastic_store_reset <= 2'h0;
        end else begin
            elastic_store_reset <= {es_hi_edge, es_lo_edge};
        end
    end

    // Receive pulse pin, the selected boundary one cycle late
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_src;
        end
    end

    // Line recovery timer; busy stays high while it runs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            recover_cnt_reg <= 32'h0;
        end else begin
            recover_cnt_reg <= recover_cnt_next;
        end
    end
endmodule : erc_receive_control_regs

/* erc_regs_assertions.sv */
// Port assertions for the receive control register bank
`timescale 1ns/1ps
module erc_regs_chk (
    input logic clk,
    input logic resetn,
    input logic transceiver_select_low,
    input logic reg_wr,
    input logic reg_rd,
    input logic [erc_pkg::ADDR_W-1:0] reg_addr,
    input logic [erc_pkg::DATA_W-1:0] reg_wdata,
    input logic [erc_pkg::DATA_W-1:0] reg_rdata,
    input logic receive_frame_pulse_oe,
    input logic receive_buffer_enable,
    input logic resync_start,
    input logic line_interface_reset,
    input logic line_interface_busy
);
    import erc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic rs_reg;
    // Decodes, and a copy of the stored resync bit to see its rising edge
    wire wr_rc = reg_wr && reg_addr == ADDR_RECEIVE_CONTROL;
    wire rd_id = reg_rd && reg_addr == ADDR_CHIP_IDENTITY;
    always_ff @(posedge clk or negedge resetn)
        rs_reg <= !resetn ? 1'b0 : wr_rc ? reg_wdata[RC_RESYNC] : rs_reg;
    sequence s_rise;
        wr_rc && reg_wdata[RC_RESYNC] && !rs_reg;
    endsequence
    a_resync_start: assert property (s_rise |-> ##[1:2] resync_start)
        else $error("no resync");
    a_resync_once: assert property (resync_start |=> !resync_start)
        else $error("long resync");
    a_line_once: assert property (line_interface_reset |=> !line_interface_reset)
        else $error("long reset");
    a_line_busy: assert property (line_interface_reset |=> line_interface_busy [*8])
        else $error("busy short");
    a_id_value: assert property (rd_id && !transceiver_select_low ##1 !reg_rd |=>
        reg_rdata == {DEVICE_CODE, CHIP_REVISION}) else $error("bad id");
    a_id_absent: assert property (rd_id && transceiver_select_low ##1 !reg_rd |=>
        reg_rdata == 8'h00) else $error("id seen");
    a_buf_follow: assert property (wr_rc |=> receive_buffer_enable == $past(reg_wdata[RC_BUF_EN]))
        else $error("bad buffer");
    a_pin_dir: assert property (wr_rc |=> receive_frame_pulse_oe ==
        !($past(reg_wdata[RC_DIR]) && $past(reg_wdata[RC_BUF_EN]))) else $error("bad dir");
endmodule : erc_regs_chk
bind erc_receive_control_regs erc_regs_chk u_chk (.*);

/* erc_host.sv */
// Host model driving the register access strobes
`timescale 1ns/1ps
module erc_host (
    input logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [erc_pkg::ADDR_W-1:0] reg_addr,
    output logic [erc_pkg::DATA_W-1:0] reg_wdata
);
    import erc_pkg::*;
    initial {reg_rd, reg_wr, reg_addr, reg_wdata} = 16'h0000;
    // One access for one edge; a released bus shows the inverse, not stale data
    task acc(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1 {reg_rd, reg_wr, reg_addr, reg_wdata} = {rd, !rd, a, d};
        @(posedge clk);
        #1 {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    endtask : acc
endmodule : erc_host

/* testbench.sv */
// Self-checking bench for the receive control register bank
`timescale 1ns/1ps
module testbench;
    import erc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sel_lo = 1'b0;
    logic [6:0] fr = 7'h00;
    logic reg_wr, reg_rd, oe, buf_en, rs, lr, busy, rfp;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [1:0] es;
    int n_errors = 0;
    int check_count = 0;
    int n_rs = 0, n_lr = 0, n_es = 0, n_fp = 0, n_bz = 0, k;
    initial forever #2 clk = ~clk;
    // Count output pulses and busy cycles
    always @(posedge clk) begin
        n_rs += rs;
        n_lr += lr;
        n_es += es == 2'b11;
        n_fp += rfp;
        n_bz += busy;
    end
    erc_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    erc_receive_control_regs #(.RECOVER_CYC(20)) dut (.clk, .resetn,
        .transceiver_select_low(sel_lo), .transceiver_select_high(1'b0), .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .fas_check(fr[6]), .fas_err(fr[5]),
        .nfas_check(fr[4]), .nfas_bit2_err(fr[3]), .frame_boundary(fr[2]),
        .cas_mf_boundary(fr[1]), .crc4_mf_boundary(fr[0]), .receive_frame_pulse_out(rfp),
        .receive_frame_pulse_oe(oe), .receive_buffer_enable(buf_en), .resync_start(rs),
        .line_interface_reset(lr), .line_interface_busy(busy), .elastic_store_reset(es));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task wc(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        host.acc(1'b0, a, d);
    endtask : wc
    task rc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        host.acc(1'b1, a, 8'h00);
        wt(1);
        chk("rdata", e, reg_rdata);
    endtask : rc
    // Framer indication pulses, one idle cycle apart
    task fp(input logic [6:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            #1 fr = v;
            @(posedge clk);
            #1 fr = 7'h00;
        end
        wt(3);
    endtask : fp
    task stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        wt(16);
        resetn = 1'b1;
        wc(ADDR_FACTORY_TEST, 8'h00);
        wc(ADDR_RECEIVE_CONTROL, 8'h00);
        wc(ADDR_COMMON_CONTROL_FIVE, 8'h10);
        wc(ADDR_COMMON_CONTROL_FOUR, 8'h60);
        wt(30);
        chk("line_rst", 1, n_lr);
        chk("busy", 20, n_bz);
        chk("es_rst", 1, n_es);
        $display("test power_up done");
        wc(ADDR_CHIP_IDENTITY, 8'hff);
        rc(ADDR_CHIP_IDENTITY, {DEVICE_CODE, CHIP_REVISION});
        rc(ADDR_FACTORY_TEST, 8'h00);
        sel_lo = 1'b1;
        wt(4);
        rc(ADDR_CHIP_IDENTITY, 8'h00);
        sel_lo = 1'b0;
        k = n_rs;
        wc(ADDR_RECEIVE_CONTROL, 8'h03);
        wc(ADDR_RECEIVE_CONTROL, 8'h03);
        wc(ADDR_RECEIVE_CONTROL, 8'h02);
        wc(ADDR_RECEIVE_CONTROL, 8'h03);
        wt(3);
        chk("resync", k + 2, n_rs);
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            wc(ADDR_RECEIVE_CONTROL, {2'b00, i < 2, i == 0, 4'h0});
            chk("pulse_oe", i != 0, oe);
            chk("buf_en", i == 0, buf_en);
            wc(ADDR_RECEIVE_CONTROL, {i == 2, i != 0, 6'h00});
            for (int b = 0; b < 3; b++) begin
                k = n_fp;
                fp(7'h04 >> b, 1);
                chk("frame_pulse", i == b, n_fp - k);
            end
        end
        $display("test pulse done");
        for (int i = 0; i < 4; i++) begin
            wc(ADDR_RECEIVE_CONTROL, {5'h00, i == 3, i == 1, 1'b0});
            fp(7'h40, 1);
            fp(7'h10, 1);
            k = n_rs;
            fp(i < 2 ? 7'h60 : 7'h18, 3);
            chk("auto_resync", i == 0 || i == 3, n_rs - k);
        end
        $display("test resync done");
        stop_test();
    end
endmodule : testbench
